// [src/timing_input_router.sv]
// module: function pin router with acquisition start and reference trigger sequencing
`timescale 1ns/1ps
module timing_input_router (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   // function pins
   input wire logic [pin_router_pkg::NUM_PINS-1:0] pinIn,
   output logic [pin_router_pkg::NUM_PINS-1:0] pinOut,
   output logic [pin_router_pkg::NUM_PINS-1:0] pinOe_n,
   // internal timing signals to drive out on each pin except the start pin, which carries the start echo
   input wire logic [pin_router_pkg::NUM_PINS-1:0] internalSig,
   // configuration
   input wire logic [pin_router_pkg::NUM_SIGS*pin_router_pkg::SEL_W-1:0] srcSel,
   input wire logic [pin_router_pkg::NUM_PINS-1:0] pinInvert,
   input wire logic [pin_router_pkg::NUM_PINS-1:0] pinDrvEn,
   input wire logic preTrigMode,
   input wire logic [pin_router_pkg::CNT_W-1:0] preScanCount,
   input wire logic [pin_router_pkg::CNT_W-1:0] postScanCount,
   input wire logic [pin_router_pkg::CNT_W-1:0] scanInterval,
   // commands
   input wire logic swStart,
   input wire logic swStop,
   // status and events
   output logic [pin_router_pkg::NUM_SIGS-1:0] routedSig,
   output logic acqActive,
   output logic keepSample,
   output logic refSeen,
   output logic scanStartPulse
);
   import pin_router_pkg::*;

   typedef enum logic [1:0] {IDLE, PRE, POST} acq_e;

   typedef struct packed {
      acq_e state;
      logic [CNT_W-1:0] scanCnt;
      logic [CNT_W-1:0] intCnt;
      logic [3:0] pulseCnt;
      logic [NUM_PINS-1:0] out;
      logic [NUM_PINS-1:0] oeN;
      logic [NUM_SIGS-1:0] routed;
      logic active;
      logic keep;
      logic refHit;
      logic scanPulse;
   } rtr_s;

   rtr_s st_ff;
   rtr_s nxt_st;
   logic [NUM_SIGS-1:0] pinDet [NUM_PINS];
   logic [NUM_SIGS-1:0] sigVal;
   logic startEv;
   logic refEv;
   logic scanTick;

   // ****************************************
   // per-pin detectors, one per signal and pin
   // ****************************************
   // each signal has its own detector per pin so edge and level can differ
   // on a shared pin; costs area, keeps detection set by the signal
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      for (genvar s = 0; s < NUM_SIGS; s++) begin : g_sig
         pin_edge_detect u_det (
            .clk(clk),
            .sysRst(sys_rst),
            .clkEn(clkEn),
            .pinIn(pinIn[p]),
            .invert(pinInvert[p]),
            .levelMode(LEVEL_MASK[s]),
            .detOut(pinDet[p][s])
         );
      end
   end

   // ****************************************
   // source selection
   // ****************************************
   always_comb begin
      for (int s = 0; s < NUM_SIGS; s++) begin
         logic [SEL_W-1:0] sel;
         sel = srcSel[s*SEL_W +: SEL_W];
         // out-of-range selection routes nothing
         sigVal[s] = (int'(sel) < NUM_PINS) ? pinDet[sel][s] : 1'b0;
      end
   end

   assign startEv = sigVal[SIG_START] | swStart;
   assign refEv = sigVal[SIG_REF];
   assign scanTick = (st_ff.intCnt == CNT_RST);

   // ****************************************
   // acquisition sequencer
   // ****************************************
   always_comb begin
      nxt_st = st_ff;
      nxt_st.scanPulse = 1'b0;
      nxt_st.routed = sigVal;
      // decrement first so a fresh start reloads the full echo width
      if (st_ff.pulseCnt != 4'h0) begin
         nxt_st.pulseCnt = st_ff.pulseCnt - 4'h1;
      end
      unique case (st_ff.state)
         IDLE: begin
            if (startEv) begin
               // start loads the scan interval counter
               nxt_st.intCnt = scanInterval;
               nxt_st.pulseCnt = PULSE_CYC_W;
               nxt_st.active = 1'b1;
               nxt_st.refHit = 1'b0;
               if (preTrigMode) begin
                  nxt_st.state = PRE;
                  nxt_st.scanCnt = preScanCount;
                  nxt_st.keep = 1'b1;
               end else begin
                  nxt_st.state = POST;
                  nxt_st.scanCnt = postScanCount;
                  nxt_st.keep = 1'b1;
               end
            end
         end
         PRE, POST: begin
            if (scanTick) begin
               nxt_st.intCnt = scanInterval;
               nxt_st.scanPulse = 1'b1;
               if (st_ff.scanCnt != CNT_RST) begin
                  nxt_st.scanCnt = st_ff.scanCnt - 16'h0001;
               end
            end else begin
               nxt_st.intCnt = st_ff.intCnt - 16'h0001;
            end
            // reference trigger only counts once pre count has run out
            if (st_ff.state == PRE && refEv && st_ff.scanCnt == CNT_RST) begin
               nxt_st.state = POST;
               nxt_st.scanCnt = postScanCount;
               nxt_st.refHit = 1'b1;
            end else if (st_ff.state == POST && scanTick && st_ff.scanCnt == CNT_RST) begin
               // sample counter stops the interval counter
               nxt_st.state = IDLE;
               nxt_st.active = 1'b0;
               nxt_st.keep = 1'b0;
            end
            if (swStop) begin
               nxt_st.state = IDLE;
               nxt_st.active = 1'b0;
               nxt_st.keep = 1'b0;
            end
         end
         default: begin
            nxt_st.state = IDLE;
         end
      endcase
      // ****************************************
      // pin drivers
      // ****************************************
      for (int p = 0; p < NUM_PINS; p++) begin
         nxt_st.oeN[p] = ~pinDrvEn[p];
         nxt_st.out[p] = internalSig[p];
      end
      // start pin echoes whatever began acquisition
      nxt_st.out[START_PIN] = (nxt_st.pulseCnt != 4'h0);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_ff <= '0;
         st_ff.state <= IDLE;
         st_ff.oeN <= '1;
      end else if (clkEn) begin
         st_ff <= nxt_st;
      end
   end

   assign pinOut = st_ff.out;
   assign pinOe_n = st_ff.oeN;
   assign routedSig = st_ff.routed;
   assign acqActive = st_ff.active;
   assign keepSample = st_ff.keep;
   assign refSeen = st_ff.refHit;
   assign scanStartPulse = st_ff.scanPulse;

   // ****************************************
   // checks
   // ****************************************
   start_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(st_ff.out[START_PIN]) |-> st_ff.out[START_PIN] [*5])
      else $error("start echo shorter than 50 ns");
   start_begins_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && st_ff.state == IDLE && startEv |=> st_ff.active)
      else $error("start trigger did not begin acquisition");
   drv_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn |=> st_ff.oeN == ~$past(pinDrvEn))
      else $error("pin driver enable mismatch");
   ref_ignored_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && st_ff.state == PRE && st_ff.scanCnt != CNT_RST && !swStop |=>
      st_ff.state == PRE)
      else $error("reference trigger taken early");
   tristate_reset_a: assert property (@(posedge clk)
      $past(sys_rst) |-> st_ff.oeN == '1)
      else $error("pin driven after reset");
   sw_start_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && st_ff.state == IDLE && swStart && preTrigMode |=> st_ff.state == PRE)
      else $error("software start ignored");
   keep_active_a: assert property (@(posedge clk) disable iff (sys_rst)
      st_ff.keep == st_ff.active)
      else $error("sample keep disagrees with activity");
   interval_run_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && st_ff.state == IDLE && startEv |=> st_ff.intCnt == $past(scanInterval))
      else $error("interval counter not loaded by start");
endmodule

// [inc/pin_router_pkg.sv]
// package: constants for the timing input router and start trigger
package pin_router_pkg;
   localparam int NUM_PINS = 10;
   localparam int NUM_SIGS = 13;
   localparam int SEL_W = 4;
   localparam int CNT_W = 16;
   // timing signal indices
   localparam logic [SEL_W-1:0] SIG_START = 4'h0;
   localparam logic [SEL_W-1:0] SIG_REF = 4'h1;
   localparam logic [SEL_W-1:0] SIG_SCAN = 4'h2;
   localparam logic [SEL_W-1:0] SIG_GATE = 4'h4;
   localparam logic [SEL_W-1:0] SIG_SICLK = 4'h5;
   // timing signals that are level-detected (others edge): gate and interval clock
   localparam logic [NUM_SIGS-1:0] LEVEL_MASK = 13'h0030;
   // pin driving the start trigger echo
   localparam int START_PIN = 0;
   // start echo pulse width: 50 to 100 ns, clock 10 ns
   localparam int CLK_PERIOD_NS = 10;
   localparam int PULSE_MIN_NS = 50;
   localparam int PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] PULSE_CYC_W = 4'(PULSE_CYC);
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
endpackage

// [src/pin_edge_detect.sv]
// module: synchroniser with polarity and edge or level detection
`timescale 1ns/1ps
module pin_edge_detect (
   // clock
   input wire logic clk,
   input wire logic sysRst,
   input wire logic clkEn,
   // pin and mode
   input wire logic pinIn,
   input wire logic invert,
   input wire logic levelMode,
   // result
   output logic detOut
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic prev;
      logic det;
      logic [1:0] fill;
   } det_s;
   det_s st_ff;
   det_s nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.meta = pinIn;
      nxt_st.sync = st_ff.meta;
      nxt_st.prev = st_ff.sync ^ invert;
      if (st_ff.fill != 2'h3) begin
         nxt_st.fill = st_ff.fill + 2'h1;
      end
      // one pulse per qualifying edge, level passed straight through
      if (levelMode) begin
         nxt_st.det = st_ff.sync ^ invert;
      end else begin
         // chain is flushed by reset: hold off until prev is a real sample,
         // else a pin idling high (or inverted low) fakes an edge
         nxt_st.det = (st_ff.sync ^ invert) & ~st_ff.prev & (st_ff.fill == 2'h3);
      end
   end

   always_ff @(posedge clk) begin
      if (sysRst) begin
         st_ff <= '0;
      end else if (clkEn) begin
         st_ff <= nxt_st;
      end
   end

   assign detOut = st_ff.det;

   edge_single_a: assert property (@(posedge clk) disable iff (sysRst)
      clkEn && !levelMode && st_ff.det ##1 clkEn |-> !st_ff.det)
      else $error("edge detect gave two pulses in a row");
endmodule

// [testbench/trig_source_model.sv]
// model: external trigger sources that let go of pins the router drives
`timescale 1ns/1ps
module trig_source_model (
   // router pin side
   input wire logic [pin_router_pkg::NUM_PINS-1:0] pinOut,
   input wire logic [pin_router_pkg::NUM_PINS-1:0] pinOe_n,
   // levels the sources want
   input wire logic [pin_router_pkg::NUM_PINS-1:0] extLevel,
   // resolved pin levels
   output logic [pin_router_pkg::NUM_PINS-1:0] pinIn
);
   import pin_router_pkg::*;
   // a source never fights an enabled driver, so the wire shows the router's value
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pinIn[i] = pinOe_n[i] ? extLevel[i] : pinOut[i];
      end
   end
endmodule

// [testbench/tb.sv]
// testbench: routing, start trigger and pretrigger sequence of the router
`timescale 1ns/1ps
module tb;
   import pin_router_pkg::*;
   logic clk, sys_rst, clkEn, preTrigMode, swStart, swStop;
   logic acqActive, keepSample, refSeen, scanStartPulse;
   logic [NUM_PINS-1:0] pinIn, pinOut, pinOe_n, internalSig, pinInvert, pinDrvEn, extLevel;
   logic [NUM_SIGS*SEL_W-1:0] srcSel;
   logic [CNT_W-1:0] preScanCount, postScanCount, scanInterval;
   logic [NUM_SIGS-1:0] routedSig;
   int n_mismatch = 0;
   int checks_done = 0;
   int width;
   timing_input_router u_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .pinIn(pinIn),
      .pinOut(pinOut), .pinOe_n(pinOe_n), .internalSig(internalSig), .srcSel(srcSel),
      .pinInvert(pinInvert), .pinDrvEn(pinDrvEn), .preTrigMode(preTrigMode),
      .preScanCount(preScanCount), .postScanCount(postScanCount),
      .scanInterval(scanInterval), .swStart(swStart), .swStop(swStop),
      .routedSig(routedSig), .acqActive(acqActive), .keepSample(keepSample),
      .refSeen(refSeen), .scanStartPulse(scanStartPulse));
   trig_source_model u_src (.pinOut(pinOut), .pinOe_n(pinOe_n), .extLevel(extLevel),
      .pinIn(pinIn));
   // ****************
   // tasks
   // ****************
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) begin
         @(posedge clk);
         #1;
      end
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, got);
      end
   endtask
   function automatic logic pick(input int which);
      case (which)
         0: return acqActive;
         1: return refSeen;
         default: return scanStartPulse;
      endcase
   endfunction
   // bounded wait; running out counts as a mismatch and ends the run
   task automatic wait_on(input int which, input logic val, input int bound);
      int i;
      for (i = 0; i < bound; i++) begin
         if (pick(which) === val) break;
         cyc(1);
      end
      checks_done++;
      if (i == bound) begin
         n_mismatch++;
         $display("[ERR] wait %0d expected %0b seen timeout", which, val);
         close_out();
      end
   endtask
   task automatic route(input int sig, input int pin);
      srcSel[sig*SEL_W +: SEL_W] = SEL_W'(pin);
   endtask
   task automatic stop_acq();
      swStop = 1'b1;
      cyc(1);
      swStop = 1'b0;
      wait_on(0, 1'b0, 4);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      {sys_rst, clkEn} = 2'b11;
      {preTrigMode, swStart, swStop} = 3'b000;
      {internalSig, pinInvert, pinDrvEn, extLevel} = '0;
      srcSel = '1;
      {preScanCount, postScanCount, scanInterval} = '0;
      cyc(20);
      sys_rst = 1'b0;
      chk("pinOe_n", 16'h03FF, pinOe_n);
      chk("acqActive", 16'h0000, acqActive);
      for (int p = 0; p < NUM_PINS; p++) begin
         route(SIG_GATE, p);
         extLevel[p] = 1'b1;
         cyc(5);
         chk("gate", 16'h0001, routedSig[SIG_GATE]);
         pinInvert[p] = 1'b1;
         cyc(5);
         chk("gateInv", 16'h0000, routedSig[SIG_GATE]);
         extLevel[p] = 1'b0;
         cyc(5);
         chk("gateInvLow", 16'h0001, routedSig[SIG_GATE]);
         pinInvert[p] = 1'b0;
         cyc(5);
      end
      clkEn = 1'b0;
      extLevel[9] = 1'b1;
      cyc(6);
      chk("gateFrozen", 16'h0000, routedSig[SIG_GATE]);
      clkEn = 1'b1;
      cyc(5);
      chk("gateThawed", 16'h0001, routedSig[SIG_GATE]);
      extLevel[9] = 1'b0;
      pinDrvEn[5] = 1'b1;
      internalSig[5] = 1'b1;
      cyc(2);
      chk("pin5Out", 16'h0001, pinOut[5]);
      chk("oe", 16'h03DF, pinOe_n);
      internalSig[5] = 1'b0;
      cyc(2);
      chk("pin5Low", 16'h0000, pinOut[5]);
      route(SIG_START, 3);
      // long interval so a run outlasts the stop and retrigger checks
      scanInterval = 16'h0020;
      pinDrvEn[0] = 1'b1;
      cyc(2);
      chk("startOe", 16'h0000, pinOe_n[0]);
      extLevel[3] = 1'b1;
      wait_on(0, 1'b1, 8);
      width = 0;
      while (pinOut[0] === 1'b1 && width < 20) begin
         width++;
         cyc(1);
      end
      chk("echoCyc", 16'(PULSE_CYC), 16'(width));
      chk("echoNs", 16'h0001, 16'(width * 10 >= 50 && width * 10 <= 100));
      stop_acq();
      pinInvert[3] = 1'b1;
      cyc(6);
      chk("noRetrig", 16'h0000, acqActive);
      extLevel[3] = 1'b0;
      wait_on(0, 1'b1, 8);
      stop_acq();
      pinInvert[3] = 1'b0;
      {preTrigMode, preScanCount, postScanCount, scanInterval} = {1'b1, 16'h2, 16'h1, 16'h3};
      route(SIG_REF, 2);
      cyc(4);
      swStart = 1'b1;
      cyc(1);
      swStart = 1'b0;
      chk("swStart", 16'h0001, acqActive);
      chk("keepPre", 16'h0001, keepSample);
      chk("swEcho", 16'h0001, pinOut[0]);
      extLevel[2] = 1'b1;
      cyc(2);
      extLevel[2] = 1'b0;
      cyc(4);
      chk("refEarly", 16'h0000, refSeen);
      wait_on(2, 1'b1, 20);
      cyc(30);
      extLevel[2] = 1'b1;
      cyc(2);
      extLevel[2] = 1'b0;
      wait_on(1, 1'b1, 10);
      chk("keepPost", 16'h0001, keepSample);
      wait_on(0, 1'b0, 40);
      chk("keepIdle", 16'h0000, keepSample);
      close_out();
   end
endmodule
